// File: inc/msc_pkg.sv
// Purpose: Shared constants and carriers for the MCU status/control register bank
// Assumes: AHB-Lite word-aligned byte registers, byte address = index * 4
// Notes:   Offsets and the named reset values live here; other resets are literals in msc_regs
package msc_pkg;
	////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam logic [4:0] IDX_WIDEBAND = 5'h00;
	localparam logic [4:0] IDX_INT_CTRL = 5'h02;
	localparam logic [4:0] IDX_CLK_DIV  = 5'h0a;
	localparam logic [4:0] IDX_RSSI     = 5'h0b;
	localparam logic [4:0] IDX_BATTERY  = 5'h0c;
	localparam logic [4:0] IDX_LCD      = 5'h0d;
	localparam logic [4:0] IDX_MISC     = 5'h0e;
	localparam logic [4:0] IDX_TXI_OFS  = 5'h0f;
	localparam logic [4:0] IDX_TXQ_OFS  = 5'h10;
	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int WBC_LOCK_BIT   = 7;
	localparam int WBC_ON_BIT     = 6;
	localparam int WBC_BW_LSB     = 3;
	localparam int INT_CLR_WB_BIT = 7;
	localparam int INT_CLR_F_BIT  = 6;
	localparam int INT_CLR_D_BIT  = 5;
	localparam int INT_SEND_C_BIT = 4;
	localparam int INT_GAIN_BIT   = 3;
	localparam int INT_FREQ_BIT   = 2;
	localparam int INT_FM_BIT     = 1;
	localparam int MISC_CLKEN_BIT = 4;
	localparam int MISC_FS_LSB    = 1;
	localparam int MISC_PA_BIT    = 0;
	localparam int LCD_LEVEL_LSB  = 4;
	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [5:0] DIV_RST      = 6'h20;
	localparam logic [2:0] WBC_BW_RST   = 3'h6;
	localparam logic       CLKEN_RST    = 1'b1;
	localparam logic       CONV_RST     = 1'b1;
	localparam logic       SYN_RDY_RST  = 1'b1;
	localparam logic [3:0] LCD_LVL_RST  = 4'h0;
	localparam logic       LCD_ENN_RST  = 1'b1;
	localparam logic [5:0] OFS_RST      = 6'h00;
	////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic       lock;
		logic       on;
		logic [2:0] bw;
	} msc_wbc_s;
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [4:0] idx;
	} msc_req_s;
endpackage

// File: sim/msc_host.sv
// Purpose: AHB-Lite microcontroller model driving the register bank
// Assumes: One slave; hready is that slave's hreadyout
// Notes:   Each finished read is announced on rd_ev with rd_data
`timescale 1ns/1ns
module msc_host (
	input  wire logic        hclk,   // Bus clock
	input  wire logic        hready, // Bus ready
	input  wire logic [31:0] hrdata, // Read data
	output logic      [31:0] haddr,  // Byte address
	output logic      [1:0]  htrans, // Transfer type
	output logic             hwrite, // Write when high
	output logic      [2:0]  hsize,  // Always a word
	output logic      [31:0] hwdata  // Write data
);
	logic [31:0] rd_data;
	event        rd_ev;
	// Idle bus from time zero
	initial begin
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// Single transfer; holds each phase until hready, no fixed wait
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		if (!wr) begin
			rd_data = hrdata;
			-> rd_ev;
		end
	endtask
endmodule

// File: sim/tb.sv
// Purpose: Self-checking bench for the MCU status/control bank
// Assumes: Host model drives the bus; bench drives the pins
// Notes:   Reads are checked from a queue of expected bytes
`timescale 1ns/1ns
module tb;
	import msc_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, wideband_bit_valid, wideband_bit, dsp_wbc_we;
	logic [31:0] haddr, hwdata, hrdata, expq[$];
	logic [1:0] htrans, aux_fullscale_sel;
	logic [2:0] hsize, wideband_bandwidth_sel;
	logic [9:0] dsp_wbc_wdata, wideband_control;
	logic [4:0] ev_v;
	logic [7:0] rssi_result, battery_result, x;
	logic [5:0] tx_i_offset, tx_q_offset;
	logic [3:0] lcd_contrast_level;
	logic edge_detector_lock, wideband_module_on, wideband_irq, f_irq, d_irq, dsp_message_irq;
	logic gain_dac_power_en, freq_dac_power_en, fm_receive_enable, mcu_clock_tick, mcu_clock_level;
	logic synth_out_of_lock, transmitter_on_indicator, synth_busy, digital_mode, pa_request;
	logic clock_output_enable, power_amp_enable_out, tx_output_mute, contrast_dac_enable_n;
	wire logic conversion_event, wideband_irq_set, dsp_send_f, dsp_send_d, dsp_clear_c;
	int n_errors, n_checks, cyc, seed;
	assign {conversion_event, wideband_irq_set, dsp_send_f, dsp_send_d, dsp_clear_c} = ev_v;
	msc_regs msc_regs_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .wideband_bit_valid, .wideband_bit,
		.wideband_irq_set, .dsp_send_f, .dsp_send_d, .dsp_clear_c, .dsp_wbc_we, .dsp_wbc_wdata,
		.wideband_control, .edge_detector_lock, .wideband_module_on, .wideband_bandwidth_sel,
		.wideband_irq, .f_irq, .d_irq, .dsp_message_irq, .gain_dac_power_en, .freq_dac_power_en,
		.fm_receive_enable, .mcu_clock_tick, .mcu_clock_level, .synth_out_of_lock,
		.transmitter_on_indicator, .synth_busy, .conversion_event, .rssi_result, .battery_result,
		.digital_mode, .pa_request, .clock_output_enable, .aux_fullscale_sel, .power_amp_enable_out,
		.tx_output_mute, .tx_i_offset, .tx_q_offset, .lcd_contrast_level, .contrast_dac_enable_n);
	msc_host msc_host_i (.hclk, .hready(hreadyout), .hrdata, .haddr, .htrans, .hwrite, .hsize, .hwdata);
	////////////////////////////////////////////////////////////////////////
	// Clock and cycle ceiling, generous against the divider waits
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [4:0] i, input logic [7:0] d);
		msc_host_i.xfer(1'b1, {25'h0, i, 2'b00}, {24'h0, d});
	endtask
	// Expected byte queued before the read so the watcher finds it
	task automatic rd(input logic [4:0] i, input logic [7:0] e);
		expq.push_back({24'h0, e});
		msc_host_i.xfer(1'b0, {25'h0, i, 2'b00}, 32'h0);
	endtask
	task automatic ev(input logic [4:0] v);
		ev_v <= v;
		@(posedge hclk);
		ev_v <= 5'h0;
		repeat (2) @(posedge hclk);
	endtask
	// Skip two ticks so the new modulus is in force, then time one period
	task automatic per(input int n);
		int c;
		c = 0;
		repeat (2) begin
			@(posedge hclk);
			while (mcu_clock_tick !== 1'b1) @(posedge hclk);
		end
		do begin
			@(posedge hclk);
			c++;
		end while (mcu_clock_tick !== 1'b1);
		chk(c, n, "divider period");
		chk(mcu_clock_level, 1'b1, "divided level high after tick");
	endtask
	task automatic tdone(input string s);
		$display("Test %s done", s);
	endtask
	// Watcher: oldest note against each finished read
	always @(msc_host_i.rd_ev) begin
		if (expq.size() == 0) begin
			n_errors++;
			$display("Error at %0t: read with nothing expected", $time);
		end else chk(msc_host_i.rd_data, expq.pop_front(), "read data");
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'hb7b0;
		{hsel, hresetn, wideband_bit_valid, wideband_bit, dsp_wbc_we, ev_v} = 10'h200;
		{synth_out_of_lock, transmitter_on_indicator, synth_busy, digital_mode, pa_request} = 5'h0;
		{dsp_wbc_wdata, rssi_result, battery_result} = 26'h0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk({edge_detector_lock, wideband_module_on, wideband_bandwidth_sel, clock_output_enable,
			contrast_dac_enable_n, lcd_contrast_level, tx_i_offset, tx_q_offset, aux_fullscale_sel,
			power_amp_enable_out, hresp}, {2'b00, 3'b110, 2'b11, 20'h0}, "reset pins");
		rd(IDX_MISC, 8'h38);
		rd(IDX_INT_CTRL, 8'h00);
		per(32);
		tdone("reset");
		x = $random(seed);
		for (int k = 0; k < 8; k++) begin
			wideband_bit_valid <= 1'b1;
			wideband_bit <= x[k];
			@(posedge hclk);
		end
		wideband_bit_valid <= 1'b0;
		rd(IDX_WIDEBAND, x);
		x = $random(seed);
		wr(IDX_WIDEBAND, x);
		@(posedge hclk);
		chk({edge_detector_lock, wideband_module_on, wideband_bandwidth_sel, wideband_control},
			{x[7:3], x[7:3], 5'h0}, "wideband control");
		dsp_wbc_we <= 1'b1;
		dsp_wbc_wdata <= 10'h2a0;
		@(posedge hclk);
		dsp_wbc_we <= 1'b0;
		@(posedge hclk);
		chk(wideband_control, 10'h2a0, "dsp control view");
		tdone("wideband");
		wr(IDX_INT_CTRL, 8'h0f);
		rd(IDX_INT_CTRL, 8'h0e);
		chk({gain_dac_power_en, freq_dac_power_en, fm_receive_enable}, 3'h7, "dac enables");
		ev(5'h0e);
		rd(IDX_INT_CTRL, 8'hee);
		wr(IDX_INT_CTRL, 8'h0e);
		rd(IDX_INT_CTRL, 8'hee);
		wr(IDX_INT_CTRL, 8'h1e);
		rd(IDX_INT_CTRL, 8'hfe);
		chk(dsp_message_irq, 1'b1, "message raised");
		wr(IDX_INT_CTRL, 8'hee);
		rd(IDX_INT_CTRL, 8'h1e);
		chk({wideband_irq, f_irq, d_irq, dsp_message_irq}, 4'h1, "irq lines");
		ev(5'h01);
		rd(IDX_INT_CTRL, 8'h0e);
		tdone("interrupts");
		wr(IDX_CLK_DIV, 8'hc2);
		per(2);
		wr(IDX_CLK_DIV, 8'h05);
		per(5);
		wr(IDX_CLK_DIV, 8'h20);
		per(32);
		rd(IDX_CLK_DIV, 8'h00);
		tdone("divider");
		{synth_out_of_lock, transmitter_on_indicator, synth_busy, digital_mode, pa_request} <= 5'h1f;
		repeat (3) @(posedge hclk);
		rd(IDX_MISC, 8'hd8);
		wr(IDX_MISC, 8'he7);
		rd(IDX_MISC, 8'hcf);
		chk({clock_output_enable, aux_fullscale_sel}, 3'h3, "clock out and fullscale");
		chk({power_amp_enable_out, tx_output_mute}, 2'b01, "pa blocked");
		synth_out_of_lock <= 1'b0;
		synth_busy <= 1'b0;
		repeat (3) @(posedge hclk);
		chk({power_amp_enable_out, tx_output_mute}, 2'b10, "pa allowed");
		wr(IDX_MISC, 8'h00);
		repeat (2) @(posedge hclk);
		chk(power_amp_enable_out, 1'b0, "pa held off");
		rssi_result <= $random(seed);
		battery_result <= $random(seed);
		rd(IDX_MISC, 8'h68);
		rd(IDX_RSSI, rssi_result);
		rd(IDX_MISC, 8'h60);
		ev(5'h10);
		rd(IDX_MISC, 8'h68);
		rd(IDX_BATTERY, battery_result);
		rd(IDX_MISC, 8'h60);
		tdone("status");
		for (int k = 0; k < 3; k++) begin
			x = $random(seed);
			wr(IDX_TXI_OFS, x);
			wr(IDX_TXQ_OFS, ~x);
			wr(IDX_LCD, x);
			@(posedge hclk);
			chk({tx_i_offset, tx_q_offset}, {x[5:0], ~x[5:0]}, "tx trims");
			chk({lcd_contrast_level, contrast_dac_enable_n}, {x[7:4], x[0]}, "contrast");
			rd(IDX_LCD, 8'h00);
		end
		rd(5'h11, 8'h00);
		rd(5'h01, 8'h00);
		@(posedge hclk);
		tdone("trims and unmapped");
		end_sim();
	end
endmodule

// File: src/msc_regs.sv
// Purpose: MCU status and control register bank on an AHB-Lite slave port
// Assumes: One clock hclk at 50 MHz; all pin inputs synchronous to hclk
// Notes:   Zero wait states; every response OKAY; unmapped reads return zero
`timescale 1ns/1ns
module msc_regs (
	input  wire logic        hclk,               // Bus clock
	input  wire logic        hresetn,            // Async reset, active low
	input  wire logic        hsel,               // Slave select
	input  wire logic [31:0] haddr,              // Byte address
	input  wire logic [1:0]  htrans,             // Transfer type
	input  wire logic        hwrite,             // Write when high
	input  wire logic [2:0]  hsize,              // Transfer size
	input  wire logic [31:0] hwdata,             // Write data
	input  wire logic        hready,             // Bus ready in
	output logic             hreadyout,          // Slave ready
	output logic             hresp,              // Always OKAY
	output logic      [31:0] hrdata,             // Read data
	input  wire logic        wideband_bit_valid, // Demodulated bit strobe
	input  wire logic        wideband_bit,       // Demodulated bit
	input  wire logic        wideband_irq_set,   // Wide-band interrupt event
	input  wire logic        dsp_send_f,         // DSP raises F interrupt
	input  wire logic        dsp_send_d,         // DSP raises D interrupt
	input  wire logic        dsp_clear_c,        // DSP clears message line
	input  wire logic        dsp_wbc_we,         // DSP-side control write
	input  wire logic [9:0]  dsp_wbc_wdata,      // DSP-side control data
	output logic      [9:0]  wideband_control,   // Ten-bit control view
	output logic             edge_detector_lock, // Lock edge detector
	output logic             wideband_module_on, // Detector power
	output logic      [2:0]  wideband_bandwidth_sel, // Bandwidth code
	output logic             wideband_irq,       // Wide-band irq pending
	output logic             f_irq,              // F irq pending
	output logic             d_irq,              // D irq pending
	output logic             dsp_message_irq,    // Message line to DSP
	output logic             gain_dac_power_en,  // Gain DAC power
	output logic             freq_dac_power_en,  // Frequency DAC power
	output logic             fm_receive_enable,  // External FM receive
	output logic             mcu_clock_tick,     // One pulse per divided period
	output logic             mcu_clock_level,    // Divided clock level
	input  wire logic        synth_out_of_lock,  // Synth lock alarm pin
	input  wire logic        transmitter_on_indicator, // PA powered pin
	input  wire logic        synth_busy,         // Synth interface busy
	input  wire logic        conversion_event,   // Result conversion finished
	input  wire logic [7:0]  rssi_result,        // Signal strength result
	input  wire logic [7:0]  battery_result,     // Battery result
	input  wire logic        digital_mode,       // Digital mode flag
	input  wire logic        pa_request,         // Transmit path wants PA
	output logic             clock_output_enable, // Master clock out gate
	output logic      [1:0]  aux_fullscale_sel,  // {hi, lo} full-scale select
	output logic             power_amp_enable_out, // External PA enable
	output logic             tx_output_mute,     // Silence TX outputs
	output logic      [5:0]  tx_i_offset,        // I trim, two's complement
	output logic      [5:0]  tx_q_offset,        // Q trim, two's complement
	output logic      [3:0]  lcd_contrast_level, // Contrast DAC input
	output logic             contrast_dac_enable_n // DAC enable, active low
);
	import msc_pkg::*;

	msc_req_s   req_r;
	msc_wbc_s   wbc_r;
	logic [7:0] rx_bits_r;
	logic [5:0] div_r;
	logic [5:0] div_act_r;
	logic [5:0] div_cnt_r;
	logic [5:0] div_cnt_nxt;
	logic       div_wrap;
	logic       syn_rdy_r;
	logic       sol_r;
	logic       txon_r;
	logic       conv_r;
	logic [7:0] rd_nxt;
	logic       take;
	logic       wr_go;
	logic [7:0] wd;
	logic       mcu_pa_permit_r;

	////////////////////////////////////////////////////////////////////////
	// Index decode; anything above the map is unmapped
	function automatic logic [4:0] idx_of(input logic [31:0] a);
		idx_of = (a[31:7] == 25'h0) ? a[6:2] : 5'h1f;
	endfunction

	// Bus takes a transfer only on NONSEQ/SEQ with ready high
	assign take  = hsel & htrans[1] & hready;
	assign wr_go = req_r.valid & req_r.write;
	assign wd    = hwdata[7:0];

	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_r <= '0;
		end else if (hready) begin
			req_r.valid <= take;
			req_r.write <= hwrite;
			req_r.idx   <= idx_of(haddr);
		end
	end

	// Zero wait state slave, never an error
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wide-band receive shift: newest bit enters the top
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_bits_r <= 8'h00;
		end else if (wideband_bit_valid) begin
			rx_bits_r <= {wideband_bit, rx_bits_r[7:1]};
		end
	end

	// Wide-band control; bus write wins a same-cycle DSP write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wbc_r <= '{lock: 1'b0, on: 1'b0, bw: WBC_BW_RST};
		end else if (wr_go && req_r.idx == IDX_WIDEBAND) begin
			wbc_r.lock <= wd[WBC_LOCK_BIT];
			wbc_r.on   <= wd[WBC_ON_BIT];
			wbc_r.bw   <= wd[WBC_BW_LSB +: 3];
		end else if (dsp_wbc_we) begin
			wbc_r.lock <= dsp_wbc_wdata[9];
			wbc_r.on   <= dsp_wbc_wdata[8];
			wbc_r.bw   <= dsp_wbc_wdata[7:5];
		end
	end

	// Control view, reserved low bits held at zero
	assign wideband_control       = {wbc_r.lock, wbc_r.on, wbc_r.bw, 5'h00};
	assign edge_detector_lock     = wbc_r.lock;
	assign wideband_module_on     = wbc_r.on;
	assign wideband_bandwidth_sel = wbc_r.bw;

	////////////////////////////////////////////////////////////////////////
	// Interrupt pending bits; an event beats a same-cycle clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wideband_irq    <= 1'b0;
			f_irq           <= 1'b0;
			d_irq           <= 1'b0;
			dsp_message_irq <= 1'b0;
		end else begin
			if (wideband_irq_set)
				wideband_irq <= 1'b1;
			else if (wr_go && req_r.idx == IDX_INT_CTRL && wd[INT_CLR_WB_BIT])
				wideband_irq <= 1'b0;
			if (dsp_send_f)
				f_irq <= 1'b1;
			else if (wr_go && req_r.idx == IDX_INT_CTRL && wd[INT_CLR_F_BIT])
				f_irq <= 1'b0;
			if (dsp_send_d)
				d_irq <= 1'b1;
			else if (wr_go && req_r.idx == IDX_INT_CTRL && wd[INT_CLR_D_BIT])
				d_irq <= 1'b0;
			// Only the DSP may drop the message line
			if (wr_go && req_r.idx == IDX_INT_CTRL && wd[INT_SEND_C_BIT])
				dsp_message_irq <= 1'b1;
			else if (dsp_clear_c)
				dsp_message_irq <= 1'b0;
		end
	end

	// DAC power and FM receive enables
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gain_dac_power_en <= 1'b0;
			freq_dac_power_en <= 1'b0;
			fm_receive_enable <= 1'b0;
		end else if (wr_go && req_r.idx == IDX_INT_CTRL) begin
			gain_dac_power_en <= wd[INT_GAIN_BIT];
			freq_dac_power_en <= wd[INT_FREQ_BIT];
			fm_receive_enable <= wd[INT_FM_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Divider modulus register, upper two bits dropped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_r <= DIV_RST;
		end else if (wr_go && req_r.idx == IDX_CLK_DIV) begin
			div_r <= wd[5:0];
		end
	end

	// Modulus swaps only at a period boundary, so no short period is seen
	assign div_wrap    = (div_cnt_r >= div_act_r - 6'h01);
	assign div_cnt_nxt = div_wrap ? 6'h00 : div_cnt_r + 6'h01;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_act_r <= DIV_RST;
			div_cnt_r <= 6'h00;
		end else begin
			div_cnt_r <= div_cnt_nxt;
			if (div_wrap)
				div_act_r <= div_r;
		end
	end

	// Tick and a near-square level derived from the count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mcu_clock_tick  <= 1'b0;
			mcu_clock_level <= 1'b0;
		end else begin
			mcu_clock_tick  <= div_wrap;
			mcu_clock_level <= (div_cnt_nxt < {1'b0, div_act_r[5:1]});
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin mirrors; ready reads 1 out of reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sol_r     <= 1'b0;
			txon_r    <= 1'b0;
			syn_rdy_r <= SYN_RDY_RST;
		end else begin
			sol_r     <= synth_out_of_lock;
			txon_r    <= transmitter_on_indicator;
			syn_rdy_r <= ~synth_busy;
		end
	end

	// Conversion done: completion beats a same-cycle read clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			conv_r <= CONV_RST;
		end else if (conversion_event) begin
			conv_r <= 1'b1;
		end else if (take && !hwrite && (idx_of(haddr) == IDX_RSSI || idx_of(haddr) == IDX_BATTERY)) begin
			conv_r <= 1'b0;
		end
	end

	// Misc control bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clock_output_enable <= CLKEN_RST;
			aux_fullscale_sel   <= 2'h0;
			power_amp_enable_out <= 1'b0;
		end else begin
			if (wr_go && req_r.idx == IDX_MISC) begin
				clock_output_enable <= wd[MISC_CLKEN_BIT];
				aux_fullscale_sel   <= wd[MISC_FS_LSB +: 2];
			end
			power_amp_enable_out <= pa_request & mcu_pa_permit_r
				& ~(digital_mode & synth_out_of_lock);
		end
	end

	// PA permit kept apart; it gates the live enable above
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mcu_pa_permit_r <= 1'b0;
			tx_output_mute  <= 1'b0;
		end else begin
			if (wr_go && req_r.idx == IDX_MISC)
				mcu_pa_permit_r <= wd[MISC_PA_BIT];
			tx_output_mute <= digital_mode & synth_out_of_lock;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Trims and LCD contrast; reserved bits never stored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_i_offset           <= OFS_RST;
			tx_q_offset           <= OFS_RST;
			lcd_contrast_level    <= LCD_LVL_RST;
			contrast_dac_enable_n <= LCD_ENN_RST;
		end else if (wr_go) begin
			if (req_r.idx == IDX_TXI_OFS)
				tx_i_offset <= wd[5:0];
			if (req_r.idx == IDX_TXQ_OFS)
				tx_q_offset <= wd[5:0];
			if (req_r.idx == IDX_LCD) begin
				lcd_contrast_level    <= wd[LCD_LEVEL_LSB +: 4];
				contrast_dac_enable_n <= wd[0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; write-only and reserved positions read zero
	always_comb begin
		rd_nxt = 8'h00;
		case (idx_of(haddr))
			IDX_WIDEBAND: rd_nxt = rx_bits_r;
			IDX_INT_CTRL: rd_nxt = {wideband_irq, f_irq, d_irq, dsp_message_irq,
				gain_dac_power_en, freq_dac_power_en, fm_receive_enable, 1'b0};
			IDX_RSSI:     rd_nxt = rssi_result;
			IDX_BATTERY:  rd_nxt = battery_result;
			IDX_MISC:     rd_nxt = {sol_r, txon_r, syn_rdy_r, clock_output_enable,
				conv_r, aux_fullscale_sel, mcu_pa_permit_r};
			default:      rd_nxt = 8'h00;
		endcase
	end

	// Data ready at the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			hrdata <= {24'h00_0000, rd_nxt};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_rx_shift;
		@(posedge hclk) disable iff (!hresetn)
		wideband_bit_valid |=> (rx_bits_r[7] == $past(wideband_bit)) && (rx_bits_r[6:0] == $past(rx_bits_r[7:1]));
	endproperty
	a_rx_shift: assert property (p_rx_shift) else $error("wide-band shift wrong");

	property p_wbc_write;
		@(posedge hclk) disable iff (!hresetn)
		(wr_go && req_r.idx == IDX_WIDEBAND) |=> (wbc_r.lock == $past(hwdata[7])) && (wbc_r.bw == $past(hwdata[5:3]));
	endproperty
	a_wbc_write: assert property (p_wbc_write) else $error("wide-band control not loaded");

	property p_div_swap;
		@(posedge hclk) disable iff (!hresetn)
		(div_act_r != $past(div_act_r)) |-> $past(div_wrap);
	endproperty
	a_div_swap: assert property (p_div_swap) else $error("modulus changed mid period");

	property p_div_period;
		@(posedge hclk) disable iff (!hresetn)
		(div_wrap && div_act_r == DIV_RST && div_r == DIV_RST && !wr_go) ##1 (!wr_go)[*8] |-> ##24 div_wrap;
	endproperty
	a_div_period: assert property (p_div_period) else $error("divide by 32 period wrong");

	property p_send_c;
		@(posedge hclk) disable iff (!hresetn)
		(wr_go && req_r.idx == IDX_INT_CTRL && hwdata[INT_SEND_C_BIT]) |=> dsp_message_irq;
	endproperty
	a_send_c: assert property (p_send_c) else $error("message line not raised");

	property p_c_fall;
		@(posedge hclk) disable iff (!hresetn)
		$fell(dsp_message_irq) |-> $past(dsp_clear_c);
	endproperty
	a_c_fall: assert property (p_c_fall) else $error("message line dropped without DSP clear");

	property p_pa_block;
		@(posedge hclk) disable iff (!hresetn)
		power_amp_enable_out |-> $past(mcu_pa_permit_r) && !$past(digital_mode && synth_out_of_lock);
	endproperty
	a_pa_block: assert property (p_pa_block) else $error("PA enabled while blocked");

	property p_conv_clear;
		@(posedge hclk) disable iff (!hresetn)
		(take && !hwrite && idx_of(haddr) == IDX_RSSI && !conversion_event) |=> !conv_r;
	endproperty
	a_conv_clear: assert property (p_conv_clear) else $error("conversion flag not cleared");

	property p_txon_mirror;
		@(posedge hclk) disable iff (!hresetn)
		(take && !hwrite && idx_of(haddr) == IDX_MISC) |=> hrdata[6] == $past(txon_r);
	endproperty
	a_txon_mirror: assert property (p_txon_mirror) else $error("indicator mirror wrong");
endmodule
